// ### logic/efc_pkg.sv
// Package for the extended feature control register block.
// Assumes one core clock and an active-low asynchronous reset.
package efc_pkg;
    localparam logic [31:0] EFC_ADDR = 32'hC000_0080;
    localparam int EFC_WIDTH = 64;
    localparam int BIT_FAST_FAST_CALL_INSTRUCTION = 0;
    localparam int BIT_WIDE_ENABLE = 8;
    localparam int BIT_WIDE_ACTIVE = 10;
    localparam int BIT_NO_EXEC = 11;
    localparam int BIT_VIRT_EXT = 12;
    localparam int BIT_SEG_LIMIT = 13;
    localparam int BIT_FAST_SAVE = 14;
    localparam int BIT_XLAT_CACHE = 15;
    localparam int BIT_COMMIT = 17;
    localparam int BIT_INT_WBINV = 18;
    localparam int BIT_UPPER_IGNORE = 20;
    // Writable bits: 0, 8, 10..15, 17, 18, 20
    localparam logic [63:0] EFC_RW_MASK = 64'h0000_0000_0016_FD01;
    // Bits that must be zero on write: 63:21, 19, 16, 9
    localparam logic [63:0] EFC_MBZ_MASK = 64'hFFFF_FFFF_FFE9_0200;
    localparam logic [63:0] EFC_RESET = 64'h0000_0000_0000_0000;
    localparam logic [1:0] PRIV_TOP = 2'h0;
endpackage : efc_pkg

// ### logic/efc_reg.sv
// Extended feature control register, reached by register-space address.
// Assumes the core presents one access per cycle with its current
// privilege level and the paging enable state.
`timescale 1ns/1ps
`default_nettype none
module efc_reg (
    input wire logic clk,               // Core clock, 20 MHz
    input wire logic nrst,              // Async reset, active low
    input wire logic acc_rd,            // Read request, one cycle
    input wire logic acc_wr,            // Write request, one cycle
    input wire logic [31:0] acc_addr,   // Register-space address
    input wire logic [63:0] acc_wdata,  // Write data
    input wire logic [1:0] acc_priv,    // Current privilege level
    input wire logic paging_enabled,    // Paging on, same clock domain
    output logic [63:0] acc_rdata,      // Read data, registered
    output logic acc_ack,               // Access accepted, registered
    output logic acc_fault,             // General-protection fault
    output logic fast_fast_call_instruction_enable,   // Fast call/return allowed
    output logic wide_mode_enable,      // Wide mode armed
    output logic wide_mode_active,      // Wide mode running
    output logic no_exec_enable,        // No-execute protection
    output logic virt_machine_ext_enable, // VM extensions
    output logic segment_limit_check_enable, // Segment limit checks
    output logic fast_save_enable,      // Fast save/restore
    output logic xlat_cache_ext_enable, // Translation cache extension
    output logic commit_enable,         // Commit instruction
    output logic int_wbinv_enable,      // Interruptible writeback
    output logic upper_addr_ignore_enable // Upper address ignore
);
    typedef struct packed {
        logic [63:0] value;
        logic [63:0] rdata;
        logic ack;
        logic fault;
    } efc_state_t;

    efc_state_t st_q, st_d;
    logic hit, priv_ok, bad_active, bad_mbz;

    assign hit = (acc_addr == efc_pkg::EFC_ADDR);
    assign priv_ok = (acc_priv == efc_pkg::PRIV_TOP);
    assign bad_active = acc_wdata[efc_pkg::BIT_WIDE_ACTIVE] !=
        st_q.value[efc_pkg::BIT_WIDE_ACTIVE];
    // Nonzero must-be-zero bits are refused rather than silently dropped
    assign bad_mbz = |(acc_wdata & efc_pkg::EFC_MBZ_MASK);

    // Decoded access classes, shared by the checks below
    logic wr_take, rd_take, wr_refused;
    assign wr_take = hit && acc_wr && priv_ok && !bad_active && !bad_mbz;
    assign rd_take = hit && acc_rd && !acc_wr && priv_ok;
    assign wr_refused = hit && acc_wr && !wr_take;

    // Undefined positions never reach the register or the read bus
    function automatic logic [63:0] efc_defined(input logic [63:0] v);
        return v & efc_pkg::EFC_RW_MASK;
    endfunction

    always_comb begin
        st_d = st_q;
        st_d.ack = 1'b0;
        st_d.fault = 1'b0;
        if (hit && (acc_rd || acc_wr)) begin
            if (!priv_ok) begin
                st_d.fault = 1'b1;
            end else if (acc_wr) begin
                if (bad_active || bad_mbz) begin
                    st_d.fault = 1'b1;
                end else begin
                    st_d.value = efc_defined(acc_wdata);
                    st_d.ack = 1'b1;
                end
            end else begin
                st_d.rdata = efc_defined(st_q.value);
                st_d.ack = 1'b1;
            end
        end
        // Hardware owns the active bit; follows enable and paging
        st_d.value[efc_pkg::BIT_WIDE_ACTIVE] =
            st_d.value[efc_pkg::BIT_WIDE_ENABLE] && paging_enabled;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= '{value: efc_pkg::EFC_RESET, rdata: 64'h0,
                      ack: 1'b0, fault: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign acc_rdata = st_q.rdata;
    assign acc_ack = st_q.ack;
    assign acc_fault = st_q.fault;
    assign fast_fast_call_instruction_enable =
        st_q.value[efc_pkg::BIT_FAST_FAST_CALL_INSTRUCTION];
    assign wide_mode_enable = st_q.value[efc_pkg::BIT_WIDE_ENABLE];
    assign wide_mode_active = st_q.value[efc_pkg::BIT_WIDE_ACTIVE];
    assign no_exec_enable = st_q.value[efc_pkg::BIT_NO_EXEC];
    assign virt_machine_ext_enable =
        st_q.value[efc_pkg::BIT_VIRT_EXT];
    assign segment_limit_check_enable =
        st_q.value[efc_pkg::BIT_SEG_LIMIT];
    assign fast_save_enable = st_q.value[efc_pkg::BIT_FAST_SAVE];
    assign xlat_cache_ext_enable = st_q.value[efc_pkg::BIT_XLAT_CACHE];
    assign commit_enable = st_q.value[efc_pkg::BIT_COMMIT];
    assign int_wbinv_enable = st_q.value[efc_pkg::BIT_INT_WBINV];
    assign upper_addr_ignore_enable =
        st_q.value[efc_pkg::BIT_UPPER_IGNORE];

    AST_PRIV_FAULT: assert property (@(posedge clk) disable iff (!nrst)
        hit && acc_wr && !priv_ok |=> acc_fault && !acc_ack
            && $stable(st_q.value[9:0]))
        else $error("unprivileged write not refused");
    AST_WRITE_TAKES: assert property (@(posedge clk) disable iff (!nrst)
        hit && acc_wr && priv_ok && !bad_active && !bad_mbz |=>
            acc_ack && virt_machine_ext_enable == $past(acc_wdata[12])
            && fast_fast_call_instruction_enable == $past(acc_wdata[0]))
        else $error("legal write not stored");
    AST_SEG_LIMIT: assert property (@(posedge clk) disable iff (!nrst)
        hit && acc_wr && priv_ok && !bad_active && !bad_mbz |=>
            segment_limit_check_enable == $past(acc_wdata[13]))
        else $error("segment limit bit not stored");
    AST_UPPER: assert property (@(posedge clk) disable iff (!nrst)
        hit && acc_wr && priv_ok && !bad_active && !bad_mbz |=>
            upper_addr_ignore_enable == $past(acc_wdata[20]))
        else $error("upper ignore bit not stored");
    AST_ACTIVE: assert property (@(posedge clk) disable iff (!nrst)
        ##1 wide_mode_active == ($past(paging_enabled) &&
            wide_mode_enable))
        else $error("active bit does not follow enable and paging");
    AST_ACTIVE_FAULT: assert property (@(posedge clk) disable iff (!nrst)
        hit && acc_wr && priv_ok && bad_active |=> acc_fault && !acc_ack)
        else $error("active mismatch not faulted");
    AST_RAZ: assert property (@(posedge clk) disable iff (!nrst)
        hit && acc_rd && !acc_wr && priv_ok |=> acc_ack
            && acc_rdata[7:1] == 7'h00 && acc_rdata[63:21] == 43'h0)
        else $error("reserved bits read nonzero");
    AST_MISS: assert property (@(posedge clk) disable iff (!nrst)
        !hit |=> !acc_ack && !acc_fault)
        else $error("other address answered");
    AST_FAST_CALL_INSTRUCTION: assert property (@(posedge clk) disable iff (!nrst)
        !(hit && acc_wr) |=> $stable(fast_fast_call_instruction_enable))
        else $error("fast call bit changed without write");

    // Each answer traces back to one taken request
    AST_ACK_EXCL: assert property (@(posedge clk) disable iff (!nrst)
        !(acc_ack && acc_fault))
        else $error("ack and fault together");
    AST_ACK_CAUSE: assert property (@(posedge clk) disable iff (!nrst)
        acc_ack |-> $past(hit && (acc_rd || acc_wr) && priv_ok))
        else $error("ack without a privileged access");
    AST_WR_ACK: assert property (@(posedge clk) disable iff (!nrst)
        wr_take |=> acc_ack && !acc_fault)
        else $error("legal write not acknowledged");
    AST_RD_PRIV: assert property (@(posedge clk) disable iff (!nrst)
        hit && acc_rd && !priv_ok |=> acc_fault && !acc_ack)
        else $error("unprivileged read not refused");
    AST_MBZ_FAULT: assert property (@(posedge clk) disable iff (!nrst)
        hit && acc_wr && priv_ok && bad_mbz |=> acc_fault && !acc_ack)
        else $error("reserved bit write not refused");

    // Bit 10 left out: paging may move it in any cycle
    AST_FAULT_KEEPS: assert property (@(posedge clk) disable iff (!nrst)
        wr_refused |=> $stable(st_q.value[9:0])
            && $stable(st_q.value[63:11]))
        else $error("refused write changed the register");
    AST_HOLD: assert property (@(posedge clk) disable iff (!nrst)
        !(hit && acc_wr) |=> $stable(st_q.value[9:0])
            && $stable(st_q.value[63:11]))
        else $error("register changed without write");
    AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!nrst)
        (st_q.value & efc_pkg::EFC_MBZ_MASK) == 64'h0
            && st_q.value[7:1] == 7'h00)
        else $error("reserved bit held nonzero");

    AST_READ_DATA: assert property (@(posedge clk) disable iff (!nrst)
        rd_take |=> acc_rdata[0] == $past(fast_fast_call_instruction_enable)
            && acc_rdata[10] == $past(wide_mode_active)
            && acc_rdata[12] == $past(virt_machine_ext_enable)
            && acc_rdata[13] == $past(segment_limit_check_enable)
            && acc_rdata[20] == $past(upper_addr_ignore_enable)
            && acc_rdata[8] == $past(wide_mode_enable))
        else $error("read data differs from features");
    AST_RDATA_HOLD: assert property (@(posedge clk) disable iff (!nrst)
        !rd_take |=> $stable(acc_rdata))
        else $error("read data moved without a read");
    // Write wins when both strobes arrive together
    AST_DUAL: assert property (@(posedge clk) disable iff (!nrst)
        hit && acc_rd && acc_wr |=> $stable(acc_rdata))
        else $error("read served alongside a write");

    AST_OTHERS: assert property (@(posedge clk) disable iff (!nrst)
        wr_take |=> wide_mode_enable == $past(acc_wdata[8])
            && no_exec_enable == $past(acc_wdata[11])
            && fast_save_enable == $past(acc_wdata[14])
            && xlat_cache_ext_enable == $past(acc_wdata[15])
            && commit_enable == $past(acc_wdata[17])
            && int_wbinv_enable == $past(acc_wdata[18]))
        else $error("feature bit not stored");
    AST_FAST_CALL_INSTRUCTION_OFF: assert property (@(posedge clk) disable iff (!nrst)
        wr_take && !acc_wdata[0] |=> !fast_fast_call_instruction_enable)
        else $error("fast call stayed on after clear");
    AST_ACTIVE_EN: assert property (@(posedge clk) disable iff (!nrst)
        wide_mode_active |-> wide_mode_enable)
        else $error("active without enable");
    AST_ACTIVE_OFF: assert property (@(posedge clk) disable iff (!nrst)
        !paging_enabled |=> !wide_mode_active)
        else $error("active without paging");
    AST_FEATURE_HOLD: assert property (@(posedge clk) disable iff (!nrst)
        !(hit && acc_wr) |=> $stable(virt_machine_ext_enable)
            && $stable(segment_limit_check_enable)
            && $stable(upper_addr_ignore_enable))
        else $error("feature changed without write");
endmodule // efc_reg
`default_nettype wire

// ### sim/extended_feature_control_register_test.sv
// Self-checking bench for the extended feature control register.
// Assumes efc_pkg and efc_reg compiled first; bench plays the core side.
`timescale 1ns/1ps
`default_nettype none
module extended_feature_control_register_test;
    localparam logic [31:0] A = efc_pkg::EFC_ADDR;
    logic clk = 1'b0, nrst = 1'b0, acc_rd = 1'b0, acc_wr = 1'b0;
    logic paging_enabled = 1'b0;
    logic [31:0] acc_addr = 32'h0;
    logic [63:0] acc_wdata = 64'h0, acc_rdata;
    logic [1:0] acc_priv = 2'h0;
    logic acc_ack, acc_fault, fsc, wma, vme, slc, uae;
    logic wme, nxe, ffx, tce, cme, iwb;
    int mismatches = 0, samples_checked = 0;
    always #25 clk = ~clk;
    efc_reg u_efc_reg (.clk(clk), .nrst(nrst), .acc_rd(acc_rd),
        .acc_wr(acc_wr), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
        .acc_priv(acc_priv), .paging_enabled(paging_enabled),
        .acc_rdata(acc_rdata), .acc_ack(acc_ack), .acc_fault(acc_fault),
        .fast_fast_call_instruction_enable(fsc), .wide_mode_enable(wme),
        .wide_mode_active(wma), .no_exec_enable(nxe),
        .virt_machine_ext_enable(vme), .segment_limit_check_enable(slc),
        .fast_save_enable(ffx), .xlat_cache_ext_enable(tce),
        .commit_enable(cme), .int_wbinv_enable(iwb),
        .upper_addr_ignore_enable(uae));
    task automatic check(input string n, input logic [63:0] s, e);
        samples_checked++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    // Answer is sampled half a cycle after the taking edge; exp = {ack, fault}
    task automatic acc(input logic w, input logic [31:0] a,
                       input logic [63:0] d, input logic [1:0] p, exp);
        @(negedge clk);
        acc_wr = w;
        acc_rd = !w;
        acc_addr = a;
        acc_wdata = d;
        acc_priv = p;
        @(negedge clk);
        acc_wr = 1'b0;
        acc_rd = 1'b0;
        check("ack_fault", {62'h0, acc_ack, acc_fault}, {62'h0, exp});
    endtask
    task automatic rd(input logic [63:0] e);
        acc(1'b0, A, 64'h0, 2'h0, 2'h2);
        check("rdata", acc_rdata, e);
    endtask
    task automatic end_sim;
        $display("counts: %0d checked, %0d mismatches", samples_checked,
                 mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (400) @(posedge clk);
        mismatches++;
        end_sim();
    end
    initial begin
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        check("reset_features", {53'h0, fsc, vme, slc, uae, wma, wme, nxe,
              ffx, tce, cme, iwb}, 64'h0);
        rd(64'h0);
        $display("test reset done");
        // Bits 7:1 written as ones must still read back zero
        acc(1'b1, A, 64'h0016_F9FF, 2'h0, 2'h2);
        check("fsc", {63'h0, fsc}, 64'h1);
        check("vme", {63'h0, vme}, 64'h1);
        check("slc", {63'h0, slc}, 64'h1);
        check("uae", {63'h0, uae}, 64'h1);
        check("others", {58'h0, wme, nxe, ffx, tce, cme, iwb}, 64'h3F);
        rd(64'h0016_F901);
        $display("test write read done");
        acc(1'b1, A, 64'h0, 2'h3, 2'h1);
        acc(1'b0, A, 64'h0, 2'h1, 2'h1);
        acc(1'b1, A, 64'h0000_0000_0000_0200, 2'h0, 2'h1);
        acc(1'b1, A, 64'h8000_0000_0000_0000, 2'h0, 2'h1);
        acc(1'b1, A + 32'h1, 64'h0, 2'h0, 2'h0);
        rd(64'h0016_F901);
        $display("test refusals done");
        paging_enabled = 1'b1;
        @(negedge clk);
        check("wma_on", {63'h0, wma}, 64'h1);
        acc(1'b1, A, 64'h0016_F901, 2'h0, 2'h1);
        acc(1'b1, A, 64'h0016_FD01, 2'h0, 2'h2);
        rd(64'h0016_FD01);
        paging_enabled = 1'b0;
        @(negedge clk);
        check("wma_off", {63'h0, wma}, 64'h0);
        acc(1'b1, A, 64'h0, 2'h0, 2'h2);
        check("fsc_off", {63'h0, fsc}, 64'h0);
        check("others_off", {58'h0, wme, nxe, ffx, tce, cme, iwb},
              64'h0);
        $display("test wide mode done");
        end_sim();
    end
endmodule // extended_feature_control_register_test
`default_nettype wire
